// ### rtl/mie_pkg.sv
// package for the instruction execution subset core
// assumes a 14-bit program word and an 8-bit file register space of 128 entries
package mie_pkg;
  localparam int unsigned MIE_IWORD_W = 14;
  localparam int unsigned MIE_PC_W = 13;
  localparam int unsigned MIE_ADDR_W = 7;
  localparam int unsigned MIE_STACK_D = 8;
  // opcode fields, bits 11:8 of byte/file oriented words and of the or-literal word
  localparam logic [3:0] MIE_OP_MISC = 4'h0;
  localparam logic [3:0] MIE_OP_DECREMENT_FILE = 4'h3;
  localparam logic [3:0] MIE_OP_IORF = 4'h4;
  localparam logic [3:0] MIE_OP_MOVE_FILE = 4'h8;
  localparam logic [3:0] MIE_OP_INCREMENT_FILE = 4'ha;
  localparam logic [3:0] MIE_OP_INCSZ = 4'hf;
  localparam logic [3:0] MIE_OP_IORL = 4'h8;
  // literal group, bits 11:10
  localparam logic [1:0] MIE_LIT_MOVL = 2'h0;
  localparam logic [1:0] MIE_LIT_RETL = 2'h1;
  // prefixes, bits 13:12
  localparam logic [1:0] MIE_PFX_BYTE = 2'h0;
  localparam logic [1:0] MIE_PFX_JUMP = 2'h2;
  localparam logic [1:0] MIE_PFX_LIT = 2'h3;
  // full words of the misc group
  localparam logic [13:0] MIE_W_RETURN = 14'h0008;
  localparam logic [13:0] MIE_W_RETURN_FROM_IRQ = 14'h0009;
  localparam logic [13:0] MIE_W_OPTION = 14'h0062;
  // field positions
  localparam int unsigned MIE_DEST_BIT = 7;
  localparam int unsigned MIE_GIE_BIT = 7;
  localparam int unsigned MIE_PAGE_LO = 3;
  // reset values
  localparam logic [12:0] MIE_PC_RST = 13'h0000;
  localparam logic [7:0] MIE_ACC_RST = 8'h00;
  localparam logic [7:0] MIE_OPT_RST = 8'hff;
  localparam logic [7:0] MIE_ICR_RST = 8'h00;
  // fixed file addresses of the option and interrupt control registers
  localparam logic [6:0] MIE_OPT_ADDR = 7'h01;
  localparam logic [6:0] MIE_ICR_ADDR = 7'h0b;
  typedef enum logic [1:0] {
    MIE_ST_EXEC = 2'b00,
    MIE_ST_FLUSH = 2'b01
  } mie_state_t;
endpackage

// ### rtl/mie_core.sv
// execution core for a subset of an 8-bit microcontroller instruction set
// assumes program memory and file space answer combinationally in the same cycle
// What this block does
// - a destination bit of 0 sends the result to the accumulator, 1 back to the file register.
// - decrement-file subtracts one, routes by destination bit and updates only zero.
// - jump_absolute loads pc 10:0 from the literal and pc 12:11 from page latch 4:3 in two cycles.
// - increment-file adds one, routes by destination bit and updates zero.
// - increment_skip_zero changes no status and flushes the next word when the result is zero.
// - or_literal_acc ors the accumulator with the literal into the accumulator and updates zero.
// - or_acc_file ors the accumulator with the file register, routes by destination, updates zero.
// - store_acc_file copies the accumulator to the file register with no status change.
// - move_file copies the file register to the destination and updates zero.
// - the option-load word copies the accumulator into the option register, no status change.
// - return_with_literal loads the literal and pops stack_top into pc in two cycles.
// - return_from_irq pops stack_top into pc and sets global_irq_enable in two cycles.
`timescale 1ns/1ps
module mie_core
  import mie_pkg::*;
(
  input wire logic sys_clk, // core clock
  input wire logic rst_n, // synchronous reset, active low
  output logic [mie_pkg::MIE_PC_W-1:0] prog_addr, // program counter
  input wire logic [mie_pkg::MIE_IWORD_W-1:0] prog_word, // word at prog_addr
  output logic [mie_pkg::MIE_ADDR_W-1:0] file_addr, // file address of current word
  input wire logic [7:0] file_rdata, // file contents at file_addr
  output logic [mie_pkg::MIE_ADDR_W-1:0] file_waddr, // registered write address
  output logic [7:0] file_wdata, // registered write data
  output logic file_we, // one-cycle write pulse
  input wire logic [7:0] pc_high_page_latch, // page latch contents
  input wire logic [7:0] status_in, // status register contents
  input wire logic [mie_pkg::MIE_PC_W-1:0] stack_top, // top of the return stack
  output logic stack_pop, // one-cycle pop pulse
  output logic [7:0] acc, // accumulator
  output logic zero_flag, // zero flag
  output logic zero_we, // pulse: zero flag updated
  output logic [7:0] option_reg, // option configuration
  output logic global_irq_enable // interrupt control bit 7
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    mie_state_t st;
    logic [12:0] pc;
    logic [7:0] acc;
    logic z;
    logic zwe;
    logic [7:0] opt;
    logic [7:0] icr;
    logic [6:0] waddr;
    logic [7:0] wdata;
    logic we;
    logic pop;
    logic [6:0] faddr;
  } mie_regs_t;

  mie_regs_t q, d;
  logic [13:0] iw;
  logic [7:0] res;
  logic [7:0] opnd; // operand after write forwarding
  logic to_file;

  // file write that also lands in the locally held registers
  function automatic logic [7:0] mie_sel(input logic [6:0] a, input logic [6:0] t,
                                        input logic [7:0] v, input logic [7:0] old);
    mie_sel = (a == t) ? v : old;
  endfunction

  assign iw = prog_word;
  assign to_file = iw[MIE_DEST_BIT];

  // a write issued last cycle lands in the file space only at this edge, so
  // forward it; otherwise back-to-back access to one register reads stale data
  assign opnd = (q.we && q.waddr == iw[6:0]) ? q.wdata : file_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // decode and execute; the fetched word is discarded in flush state
  always_comb begin
    d = q;
    d.we = 1'b0;
    d.pop = 1'b0;
    d.zwe = 1'b0;
    res = 8'h00;
    d.pc = q.pc + 13'h0001;
    d.st = MIE_ST_EXEC;
    d.faddr = iw[6:0];
    if (q.st == MIE_ST_FLUSH) begin
      // the new address was loaded by the first cycle; hold it so it is fetched next
      d.pc = q.pc;
      d.st = MIE_ST_EXEC; // second cycle acts as a no-op
    end else if (iw[13:12] == MIE_PFX_JUMP && iw[11]) begin
      d.pc = {pc_high_page_latch[MIE_PAGE_LO+1:MIE_PAGE_LO], iw[10:0]};
      d.st = MIE_ST_FLUSH;
    end else if (iw[13:12] == MIE_PFX_LIT) begin
      if (iw[11:8] == MIE_OP_IORL) begin
        res = q.acc | iw[7:0];
        d.acc = res;
        d.z = (res == 8'h00);
        d.zwe = 1'b1;
      end else if (iw[11:10] == MIE_LIT_MOVL) begin
        d.acc = iw[7:0];
      end else if (iw[11:10] == MIE_LIT_RETL) begin
        d.acc = iw[7:0];
        d.pc = stack_top;
        d.pop = 1'b1;
        d.st = MIE_ST_FLUSH;
      end
    end else if (iw == MIE_W_RETURN) begin
      d.pc = stack_top;
      d.pop = 1'b1;
      d.st = MIE_ST_FLUSH;
    end else if (iw == MIE_W_RETURN_FROM_IRQ) begin
      d.pc = stack_top;
      d.pop = 1'b1;
      d.icr[MIE_GIE_BIT] = 1'b1;
      d.st = MIE_ST_FLUSH;
    end else if (iw == MIE_W_OPTION) begin
      d.opt = q.acc;
    end else if (iw[13:12] == MIE_PFX_BYTE) begin
      case (iw[11:8])
        MIE_OP_MISC: begin
          if (to_file) begin
            d.we = 1'b1;
            d.waddr = iw[6:0];
            d.wdata = q.acc;
            d.opt = mie_sel(iw[6:0], MIE_OPT_ADDR, q.acc, q.opt);
            d.icr = mie_sel(iw[6:0], MIE_ICR_ADDR, q.acc, q.icr);
          end
        end
        MIE_OP_DECREMENT_FILE, MIE_OP_INCREMENT_FILE, MIE_OP_IORF, MIE_OP_MOVE_FILE, MIE_OP_INCSZ: begin
          case (iw[11:8])
            MIE_OP_DECREMENT_FILE: res = opnd - 8'h01;
            MIE_OP_INCREMENT_FILE: res = opnd + 8'h01;
            MIE_OP_IORF: res = q.acc | opnd;
            MIE_OP_MOVE_FILE: res = opnd;
            default: res = opnd + 8'h01;
          endcase
          if (iw[11:8] != MIE_OP_INCSZ) begin
            d.z = (res == 8'h00);
            d.zwe = 1'b1;
          end else if (res == 8'h00) begin
            d.st = MIE_ST_FLUSH;
            d.pc = q.pc + 13'h0002; // step over the discarded word
          end
          if (to_file) begin
            d.we = 1'b1;
            d.waddr = iw[6:0];
            d.wdata = res;
            d.opt = mie_sel(iw[6:0], MIE_OPT_ADDR, res, q.opt);
            d.icr = mie_sel(iw[6:0], MIE_ICR_ADDR, res, q.icr);
          end else begin
            d.acc = res;
          end
        end
        default: d.st = MIE_ST_EXEC; // outside the subset: treated as one-cycle no-op
      endcase
    end
    if (!rst_n) begin
      d = '0;
      d.st = MIE_ST_EXEC;
      d.pc = MIE_PC_RST;
      d.acc = MIE_ACC_RST;
      d.opt = MIE_OPT_RST;
      d.icr = MIE_ICR_RST;
    end
  end

  // single state register; zero flag seeded from status on reset is not needed
  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops, except file_addr: it follows the fetched
  // word so the file space can answer within the same cycle
  assign prog_addr = q.pc;
  assign file_addr = iw[6:0];
  assign file_waddr = q.waddr;
  assign file_wdata = q.wdata;
  assign file_we = q.we;
  assign stack_pop = q.pop;
  assign acc = q.acc;
  assign zero_flag = q.z;
  assign zero_we = q.zwe;
  assign option_reg = q.opt;
  assign global_irq_enable = q.icr[MIE_GIE_BIT];

  logic status_unused;
  assign status_unused = ^status_in;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_jump_absolute_target: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.st == MIE_ST_EXEC && prog_word[13:11] == 3'b101) |=>
    (prog_addr == {$past(pc_high_page_latch[4:3]), $past(prog_word[10:0])}) && q.st == MIE_ST_FLUSH)
    else $error("jump target wrong");
  a_flush_noop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    q.st == MIE_ST_FLUSH |=> !file_we && !zero_we && !stack_pop)
    else $error("flush cycle had an effect");
  a_decrement_file_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.st == MIE_ST_EXEC && prog_word[13:8] == 6'h03) |=>
    zero_we && zero_flag == ($past(opnd) == 8'h01))
    else $error("decrement zero wrong");
  a_increment_file_dest: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.st == MIE_ST_EXEC && prog_word[13:7] == 7'h15) |=>
    file_we && file_wdata == $past(opnd) + 8'h01)
    else $error("increment write wrong");
  a_skip_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.st == MIE_ST_EXEC && prog_word[13:8] == 6'h0f && opnd == 8'hff) |=>
    q.st == MIE_ST_FLUSH && !zero_we)
    else $error("skip not taken");
  a_iorl_acc: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.st == MIE_ST_EXEC && prog_word[13:8] == 6'h38) |=>
    acc == ($past(acc) | $past(prog_word[7:0])))
    else $error("or literal wrong");
  a_load_literal_acc_nostat: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.st == MIE_ST_EXEC && prog_word[13:10] == 4'hc) |=>
    acc == $past(prog_word[7:0]) && !zero_we)
    else $error("load literal wrong");
  a_return_from_irq_gie: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.st == MIE_ST_EXEC && prog_word == 14'h0009) |=>
    global_irq_enable && stack_pop && prog_addr == $past(stack_top) ##1 !stack_pop)
    else $error("irq return wrong");
  a_option_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.st == MIE_ST_EXEC && prog_word == 14'h0062) |=> option_reg == $past(acc) && !zero_we)
    else $error("option load wrong");
  a_return_with_literal_pop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.st == MIE_ST_EXEC && prog_word[13:10] == 4'hd) |=>
    stack_pop && acc == $past(prog_word[7:0]) && q.st == MIE_ST_FLUSH)
    else $error("literal return wrong");
  a_single_cycle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.st == MIE_ST_EXEC && prog_word[13:12] == 2'b00 && prog_word[11:8] != 4'hf &&
     prog_word[11:8] != 4'h0) |=> prog_addr == $past(prog_addr) + 13'h0001)
    else $error("one-cycle word took longer");
  c_jump_absolute: cover property (@(posedge sys_clk) q.st == MIE_ST_EXEC && prog_word[13:11] == 3'b101);
  c_skip: cover property (@(posedge sys_clk) q.st == MIE_ST_EXEC && prog_word[13:8] == 6'h0f
    ##1 q.st == MIE_ST_FLUSH);
  c_ret: cover property (@(posedge sys_clk) stack_pop);
  c_option: cover property (@(posedge sys_clk) q.st == MIE_ST_EXEC && prog_word == 14'h0062);
  c_forward: cover property (@(posedge sys_clk) q.we && q.waddr == file_addr);

  ////////////////////////////////////////////////////////////////////////////
  // file-operand results; all but the accumulator store look at the forwarded operand, since the raw
  // file port is stale right after a write to the same register
  a_increment_file_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.st == MIE_ST_EXEC && prog_word[13:8] == 6'h0a) |=>
    zero_we && zero_flag == ($past(opnd) == 8'hff))
    else $error("increment zero wrong");
  a_or_acc_file_file: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.st == MIE_ST_EXEC && prog_word[13:7] == 7'h09) |=>
    file_we && zero_we && file_wdata == ($past(acc) | $past(opnd)))
    else $error("or file wrong");
  a_store_acc_file_copy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.st == MIE_ST_EXEC && prog_word[13:7] == 7'h01) |=>
    file_we && file_wdata == $past(acc) && !zero_we)
    else $error("store accumulator wrong");
  a_move_file_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.st == MIE_ST_EXEC && prog_word[13:8] == 6'h08) |=>
    zero_we && zero_flag == ($past(opnd) == 8'h00))
    else $error("move file zero wrong");
  a_dest_acc: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.st == MIE_ST_EXEC && prog_word[13:7] == 7'h14) |=>
    !file_we && acc == $past(opnd) + 8'h01)
    else $error("accumulator destination wrong");

  // control flow: the second cycle of every two-cycle word keeps the new pc
  a_return_pop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.st == MIE_ST_EXEC && prog_word == 14'h0008) |=>
    stack_pop && prog_addr == $past(stack_top) && !zero_we)
    else $error("subroutine return wrong");
  a_flush_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    q.st == MIE_ST_FLUSH |=> prog_addr == $past(prog_addr))
    else $error("flush cycle moved the pc");
  a_skip_pc: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.st == MIE_ST_EXEC && prog_word[13:8] == 6'h0f && opnd == 8'hff) |=>
    prog_addr == $past(prog_addr) + 13'h0002)
    else $error("skip address wrong");
  a_pop_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stack_pop |=> !stack_pop)
    else $error("pop longer than one cycle");
  a_nop_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.st == MIE_ST_EXEC && prog_word == 14'h0000) |=>
    !file_we && !zero_we && !stack_pop && acc == $past(acc))
    else $error("no-op had an effect");

  // reset is synchronous, so one low edge must bring every register home
  a_reset_state: assert property (@(posedge sys_clk)
    !rst_n |=> prog_addr == 13'h0000 && acc == 8'h00 && option_reg == 8'hff &&
    !global_irq_enable && !file_we && !stack_pop)
    else $error("reset state wrong");
endmodule

// ### tb/mie_mem_model.sv
// behavioural program memory, file register space and return stack for the core
// assumes the bench preloads prog, regs and stk before reset is released
`timescale 1ns/1ps
module mie_mem_model (
  input wire logic sys_clk, // core clock
  input wire logic [mie_pkg::MIE_PC_W-1:0] prog_addr, // fetch address
  output logic [mie_pkg::MIE_IWORD_W-1:0] prog_word, // word at fetch address
  input wire logic [mie_pkg::MIE_ADDR_W-1:0] file_addr, // operand read address
  output logic [7:0] file_rdata, // operand contents
  input wire logic [mie_pkg::MIE_ADDR_W-1:0] file_waddr, // write address
  input wire logic [7:0] file_wdata, // write data
  input wire logic file_we, // write pulse
  input wire logic stack_pop, // pop pulse
  output logic [mie_pkg::MIE_PC_W-1:0] stack_top // top of the return stack
);
  import mie_pkg::*;
  logic [MIE_IWORD_W-1:0] prog [2**MIE_PC_W];
  logic [7:0] regs [2**MIE_ADDR_W];
  logic [MIE_PC_W-1:0] stk [4];
  int sp = 2;
  ////////////////////////////////////////////////////////////////////////////
  // same-cycle answers, since the core reads operands combinationally
  assign prog_word = prog[prog_addr];
  assign file_rdata = regs[file_addr];
  assign stack_top = stk[sp];
  // writes land at the edge after the pulse; a pop exposes the next entry
  always @(posedge sys_clk) begin
    if (file_we === 1'b1) regs[file_waddr] <= file_wdata;
    if (stack_pop === 1'b1) sp <= sp - 1;
  end
endmodule

// ### tb/mcu_instr_exec_subset_test.sv
// self-checking bench: runs a short program and compares state every cycle
// assumes the core and mie_mem_model; inputs change at the falling edge
`timescale 1ns/1ps
module mcu_instr_exec_subset_test;
  import mie_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [MIE_PC_W-1:0] prog_addr, stack_top;
  logic [MIE_IWORD_W-1:0] prog_word;
  logic [MIE_ADDR_W-1:0] file_addr, file_waddr;
  logic [7:0] file_rdata, file_wdata, acc, option_reg;
  logic [7:0] page_latch = 8'hfb; // only bits 4:3 may reach the pc
  logic file_we, stack_pop, zero_flag, zero_we, global_irq_enable;
  int n_errors = 0;
  int n_compared = 0;
  int n_pops = 0;
  logic [13:0] code [12] = '{14'h305a, 14'h00a0, 14'h0a20, 14'h03a1, 14'h309a, 14'h3835,
    14'h04a2, 14'h0062, 14'h0820, 14'h0fa3, 14'h3077, 14'h2923};
  logic [12:0] exp_pc [21] = '{13'h0000, 13'h0001, 13'h0002, 13'h0003, 13'h0004, 13'h0005,
    13'h0006, 13'h0007, 13'h0008, 13'h0009, 13'h000b, 13'h000b, 13'h1923, 13'h1923,
    13'h0030, 13'h0030, 13'h0040, 13'h0040, 13'h0050, 13'h0050, 13'h0051};
  logic [7:0] exp_acc [21] = '{8'h00, 8'h5a, 8'h5a, 8'h5b, 8'h5b, 8'h9a, 8'hbf, 8'hbf,
    8'hbf, 8'h5a, 8'h5a, 8'h5a, 8'h5a, 8'h5a, 8'h44, 8'h44, 8'h44, 8'h44, 8'h44, 8'h44,
    8'h44};
  ////////////////////////////////////////////////////////////////////////////
  mie_core i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .prog_addr(prog_addr),
    .prog_word(prog_word), .file_addr(file_addr), .file_rdata(file_rdata),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .file_we(file_we),
    .pc_high_page_latch(page_latch), .status_in(8'h00), .stack_top(stack_top),
    .stack_pop(stack_pop), .acc(acc), .zero_flag(zero_flag), .zero_we(zero_we),
    .option_reg(option_reg), .global_irq_enable(global_irq_enable));
  mie_mem_model i_mem (.sys_clk(sys_clk), .prog_addr(prog_addr), .prog_word(prog_word),
    .file_addr(file_addr), .file_rdata(file_rdata), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .file_we(file_we), .stack_pop(stack_pop),
    .stack_top(stack_top));
  ////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // pops are counted so a double or missing pop shows up
  always @(posedge sys_clk) begin
    if (stack_pop === 1'b1) n_pops++;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // the program needs about 30 cycles, so 2000 means a hang
  initial begin
    repeat (2000) @(posedge sys_clk);
    n_errors++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  // load program, operands and stack, then trace the run cycle by cycle
  initial begin
    for (int k = 0; k < 12; k++) i_mem.prog[k] = code[k];
    i_mem.prog[13'h1923] = 14'h3444;
    i_mem.prog[13'h0030] = 14'h0009;
    i_mem.prog[13'h0040] = 14'h0008;
    i_mem.prog[13'h0050] = 14'h0000;
    i_mem.prog[13'h0051] = 14'h0000;
    i_mem.regs[7'h21] = 8'h01;
    i_mem.regs[7'h22] = 8'h13;
    i_mem.regs[7'h23] = 8'hff;
    i_mem.stk[0] = 13'h0050;
    i_mem.stk[1] = 13'h0040;
    i_mem.stk[2] = 13'h0030;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 21; i++) begin
      if (i > 0) @(negedge sys_clk);
      chk("prog_addr", exp_pc[i], prog_addr);
      chk("acc", exp_acc[i], acc);
      if (i >= 3) chk("zero_flag", i == 4 || i == 5, zero_flag);
      chk("global_irq_enable", i >= 16, global_irq_enable);
      chk("option_reg", i >= 8 ? 8'hbf : 8'hff, option_reg);
    end
    $display("program trace test done");
    chk("file 20", 8'h5a, i_mem.regs[7'h20]);
    chk("file 21", 8'h00, i_mem.regs[7'h21]);
    chk("file 22", 8'hbf, i_mem.regs[7'h22]);
    chk("file 23", 8'h00, i_mem.regs[7'h23]);
    chk("pops", 16'(n_pops), 16'h0003);
    $display("file space test done");
    give_verdict();
  end
endmodule
